/* File: hdl/chg_ctrl.sv */
// Power-up, input qualification and switch gating of the charge controller
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl
  import chg_ctrl_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire sense_type           sense_pins,
  input  wire logic                freq_set_sync_pin,
  input  wire logic [PER_W-1:0]    period_cycles,
  input  wire logic [PER_W-1:0]    duty_cycles,
  input  wire conv_mode_type       mode_sel,
  input  wire logic                light_load,
  input  wire logic                charge_enable,
  input  wire logic                reverse_enable_bit,
  input  wire logic                light_load_wr,
  input  wire logic                light_load_wdata,
  input  wire logic [REG_W-1:0]    input_regulation_register,
  input  wire logic [REG_W-1:0]    pin_regulation_level,
  output logic                     power_good_n,
  output logic                     gate_drive_regulator,
  output logic                     host_port_ready,
  output logic                     converter_on,
  output logic                     input_regulation,
  output logic [REG_W-1:0]         regulation_target,
  output logic                     light_load_enable_bit,
  output logic                     pulse_frequency_mode,
  output logic                     calibrating,
  output logic                     sync_locked,
  output gate_type                 gates
);

  // ****************************************
  // Input synchronisation and filtering
  // ****************************************
  sense_type sense;
  logic      sync_clk;
  logic      ov_filtered;

  sync_pin #(.W($bits(sense_type) + 1)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_in   ({sense_pins, freq_set_sync_pin}),
    .pin_out  ({sense, sync_clk})
  );

  ov_deglitch u_ov (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .level_in  (sense.input_overvolt_sense),
    .level_out (ov_filtered)
  );

  // ****************************************
  // Power-on reset and qualification
  // ****************************************
  logic input_ok_d;
  logic battery_ok_d;
  logic por_pulse;
  wire  input_rise   = sense.input_ok && !input_ok_d;
  wire  battery_rise = sense.battery_ok && !battery_ok_d;
  wire  next_por     = (input_rise && !battery_ok_d)
                     || (battery_rise && !input_ok_d);
  wire  in_window    = sense.input_ok && sense.input_undervolt_sense
                     && !ov_filtered;
  wire  fault_stop   = !sense.input_undervolt_sense || ov_filtered;
  wire  forward_go   = in_window && charge_enable;
  wire  reverse_go   = !sense.input_ok && sense.battery_ok
                     && reverse_enable_bit;
  wire  run_request  = forward_go || reverse_go;
  wire  next_regulator = (sense.input_ok && charge_enable)
                       || (sense.battery_ok && reverse_enable_bit);
  wire  next_ready   = sense.input_ok || sense.battery_ok;
  wire [REG_W-1:0] next_target =
    (input_regulation_register > VREG_DEFAULT
     && input_regulation_register > pin_regulation_level)
    ? input_regulation_register : pin_regulation_level;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      input_ok_d           <= 1'b0;
      battery_ok_d         <= 1'b0;
      por_pulse            <= 1'b0;
      power_good_n         <= 1'b1;
      gate_drive_regulator <= 1'b0;
      host_port_ready      <= 1'b0;
      input_regulation     <= 1'b0;
      regulation_target    <= VREG_DEFAULT;
    end else begin
      input_ok_d           <= sense.input_ok;
      battery_ok_d         <= sense.battery_ok;
      por_pulse            <= next_por;
      power_good_n         <= !in_window;
      gate_drive_regulator <= next_regulator && !fault_stop
                              || (next_regulator && reverse_go);
      host_port_ready      <= next_ready && !next_por;
      input_regulation     <= sense.input_ok
                              && !sense.input_undervolt_dpm;
      regulation_target    <= next_target;
    end
  end

  // ****************************************
  // Sync clock detection and oscillator
  // ****************************************
  logic             sync_d;
  logic [CNT_W-1:0] sync_gap;
  logic [PER_W-1:0] sync_period;
  logic [PER_W-1:0] osc_count;
  wire  sync_edge   = sync_clk && !sync_d;
  wire  gap_ok      = sync_gap >= CNT_W'(PERIOD_MIN_CYCLES - 1)
                   && sync_gap <= CNT_W'(PERIOD_MAX_CYCLES);
  wire [PER_W-1:0] active_period = sync_locked ? sync_period
                                               : period_cycles;
  wire  cycle_start = osc_count >= active_period - PER_W'(1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_d      <= 1'b0;
      sync_gap    <= '0;
      sync_period <= '0;
      sync_locked <= 1'b0;
      osc_count   <= '0;
    end else begin
      sync_d <= sync_clk;
      if (sync_edge) begin
        sync_gap    <= '0;
        sync_locked <= gap_ok;
        sync_period <= PER_W'(sync_gap + CNT_W'(1));
      end else if (sync_gap >= CNT_W'(SYNC_LOST_CYCLES)) begin
        sync_locked <= 1'b0;
      end else begin
        sync_gap <= sync_gap + CNT_W'(1);
      end
      if (cycle_start || (sync_edge && sync_locked)) begin
        osc_count <= '0;
      end else begin
        osc_count <= osc_count + PER_W'(1);
      end
    end
  end

  // ****************************************
  // Converter state, calibration, light load
  // ****************************************
  conv_state_type   state;
  conv_state_type   next_state;
  logic [CNT_W-1:0] cal_count;
  logic             cal_on_output;
  logic [2:0]       skip_count;
  logic             phase_b;
  wire  starting = state == ST_OFF && next_state == ST_CAL;
  wire  stop_all = por_pulse || (!reverse_go && fault_stop)
                 || !run_request;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:  if (run_request && !por_pulse) next_state = ST_CAL;
      ST_CAL:  if (stop_all) next_state = ST_OFF;
               else if (cal_count >= CNT_W'(CAL_CYCLES - 1))
                 next_state = ST_RUN;
      ST_RUN:  if (stop_all) next_state = ST_OFF;
      default: next_state = ST_OFF;
    endcase
  end

  wire pulse_skip = pulse_frequency_mode && light_load
                  && skip_count != 3'(PFM_SKIP_MAX);
  wire next_ll_bit = (por_pulse) ? LIGHT_LOAD_RESET
                   : (starting && sync_locked) ? 1'b0
                   : light_load_wr ? light_load_wdata
                   : light_load_enable_bit;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state                 <= ST_OFF;
      cal_count             <= '0;
      cal_on_output         <= 1'b0;
      light_load_enable_bit <= LIGHT_LOAD_RESET;
      skip_count            <= '0;
      phase_b               <= 1'b0;
    end else begin
      state                 <= next_state;
      light_load_enable_bit <= next_ll_bit;
      if (starting) begin
        cal_count     <= '0;
        cal_on_output <= sense.battery_above_low;
      end else if (state == ST_CAL) begin
        cal_count <= cal_count + CNT_W'(1);
      end
      if (cycle_start) begin
        phase_b    <= !phase_b;
        skip_count <= pulse_skip ? skip_count + 3'(1) : '0;
      end
    end
  end

  // ****************************************
  // Switch gating
  // ****************************************
  wire pwm_on  = osc_count < duty_cycles;
  wire hs_min  = osc_count < PER_W'(BOOST_HS_CYCLES);
  wire sw_buck  = pwm_on && !pulse_skip;
  wire sw_boost = (pwm_on || hs_min) && !pulse_skip;
  gate_type next_gates;

  always_comb begin
    next_gates = '0;
    case (state)
      ST_CAL: begin
        if (cal_on_output) begin
          next_gates.boost_hs = !sw_buck;
          next_gates.boost_ls = sw_buck;
          next_gates.buck_hs  = 1'b1;
        end else begin
          next_gates.buck_hs = sw_buck;
          next_gates.buck_ls = !sw_buck;
        end
      end
      ST_RUN: begin
        case (mode_sel)
          MODE_BUCK: begin
            next_gates.buck_hs  = sw_buck;
            next_gates.buck_ls  = !sw_buck && !pulse_skip;
            next_gates.boost_hs = 1'b1;
          end
          MODE_BOOST: begin
            next_gates.buck_hs  = 1'b1;
            next_gates.boost_ls = !sw_boost && !pulse_skip;
            next_gates.boost_hs = sw_boost;
          end
          default: begin
            next_gates.buck_hs  = phase_b ? 1'b1 : sw_buck;
            next_gates.buck_ls  = !phase_b && !sw_buck && !pulse_skip;
            next_gates.boost_hs = phase_b ? sw_boost : 1'b1;
            next_gates.boost_ls = phase_b && !sw_boost
                                  && !pulse_skip;
          end
        endcase
      end
      default: next_gates = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gates                <= '0;
      converter_on         <= 1'b0;
      calibrating          <= 1'b0;
      pulse_frequency_mode <= 1'b0;
    end else begin
      gates                <= next_gates;
      converter_on         <= state != ST_OFF;
      calibrating          <= state == ST_CAL;
      pulse_frequency_mode <= light_load_enable_bit;
    end
  end

endmodule : chg_ctrl
`default_nettype wire

/* File: hdl/chg_ctrl_pkg.sv */
// Package of constants and carrier types for the charger control block
package chg_ctrl_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ            = 25000000;
  localparam int CLK_NS            = 40;
  localparam int OV_ENTER_US       = 100;
  localparam int OV_EXIT_MS        = 12;
  localparam int CAL_MS            = 40;
  localparam int BOOST_HS_NS       = 225;
  localparam int OV_ENTER_CYCLES   = OV_ENTER_US * (CLK_HZ / 1000000);
  localparam int OV_EXIT_CYCLES    = OV_EXIT_MS * (CLK_HZ / 1000);
  localparam int CAL_CYCLES        = CAL_MS * (CLK_HZ / 1000);
  localparam int BOOST_HS_CYCLES   = (BOOST_HS_NS + CLK_NS - 1) / CLK_NS;
  localparam int FSW_MIN_HZ        = 200000;
  localparam int FSW_MAX_HZ        = 600000;
  localparam int PERIOD_MAX_CYCLES = CLK_HZ / FSW_MIN_HZ;
  localparam int PERIOD_MIN_CYCLES = CLK_HZ / FSW_MAX_HZ;
  localparam int SYNC_LOST_CYCLES  = 2 * PERIOD_MAX_CYCLES;
  localparam int PFM_SKIP_MAX      = 7;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int REG_W             = 16;
  localparam int CNT_W             = 20;
  localparam int PER_W             = 8;
  localparam logic [REG_W-1:0] VREG_DEFAULT = 16'h0000;
  localparam logic LIGHT_LOAD_RESET = 1'b0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MODE_BUCK, MODE_BUCK_BOOST, MODE_BOOST}
    conv_mode_type;

  typedef enum {ST_OFF, ST_CAL, ST_RUN} conv_state_type;

  typedef struct packed {
    logic buck_hs;
    logic buck_ls;
    logic boost_ls;
    logic boost_hs;
  } gate_type;

  typedef struct packed {
    logic input_ok;
    logic battery_ok;
    logic battery_above_low;
    logic input_undervolt_sense;
    logic input_undervolt_dpm;
    logic input_overvolt_sense;
  } sense_type;

endpackage : chg_ctrl_pkg

/* File: hdl/ov_deglitch.sv */
// Asymmetric deglitch filter for a synchronised comparator level
`timescale 1ns/10ps
`default_nettype none
module ov_deglitch
  import chg_ctrl_pkg::*;
#(
  parameter int RISE_CYCLES = OV_ENTER_CYCLES,
  parameter int FALL_CYCLES = OV_EXIT_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic level_in,
  output logic      level_out
);

  logic [CNT_W-1:0] count;
  wire              differs = level_in != level_out;
  wire [CNT_W-1:0]  limit   = level_out ? CNT_W'(FALL_CYCLES - 1)
                                        : CNT_W'(RISE_CYCLES - 1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count     <= '0;
      level_out <= 1'b0;
    end else if (!differs) begin
      count <= '0;
    end else if (count >= limit) begin
      count     <= '0;
      level_out <= level_in;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

endmodule : ov_deglitch
`default_nettype wire

/* File: hdl/sync_pin.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync_pin #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1  <= '0;
      pin_out <= '0;
    end else begin
      stage1  <= pin_in;
      pin_out <= stage1;
    end
  end

endmodule : sync_pin
`default_nettype wire

/* File: tb/chg_ctrl_partner.sv */
// Model of input source, battery comparators and external sync clock
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl_partner
  import chg_ctrl_pkg::*;
(
  input  wire logic      sync_on,
  input  wire sense_type want,
  output sense_type      sense_pins,
  output logic           freq_set_sync_pin
);
  // ****************************************
  // Source levels and sync clock
  // ****************************************
  localparam int HALF_NS = 1667;
  assign sense_pins = want;
  initial freq_set_sync_pin = 1'h0;
  // Clock near 300 kHz; pulled low while absent
  always begin
    #(HALF_NS);
    freq_set_sync_pin = sync_on ? !freq_set_sync_pin : 1'h0;
  end
endmodule : chg_ctrl_partner
`default_nettype wire

/* File: tb/chg_ctrl_props.sv */
// Port assertions for the charger control block
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl_props
  import chg_ctrl_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire sense_type        sense_pins,
  input wire logic             reverse_enable_bit,
  input wire logic             light_load_wr,
  input wire logic             light_load_wdata,
  input wire logic [REG_W-1:0] input_regulation_register,
  input wire logic [REG_W-1:0] pin_regulation_level,
  input wire logic             power_good_n,
  input wire logic             gate_drive_regulator,
  input wire logic             converter_on,
  input wire logic [REG_W-1:0] regulation_target,
  input wire logic             light_load_enable_bit,
  input wire logic             pulse_frequency_mode,
  input wire logic             calibrating,
  input wire logic             sync_locked
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic [REG_W-1:0] ireg = input_regulation_register;
  wire logic [REG_W-1:0] preg = pin_regulation_level;

  AST_UV_STOP: assert property ((!sense_pins.input_undervolt_sense)[*5]
    |-> power_good_n && !converter_on) else $error("undervolt not acted on");
  AST_PG_NEEDS_INPUT: assert property ((!sense_pins.input_ok)[*4]
    |-> power_good_n) else $error("power good without input");
  AST_REG_BATT_ONLY: assert property (
    (!sense_pins.input_ok && !reverse_enable_bit)[*4]
    |-> !gate_drive_regulator) else $error("regulator on battery only");
  AST_REV_NEEDS_BATT: assert property (
    (!sense_pins.input_ok && !sense_pins.battery_ok)[*4]
    |-> !gate_drive_regulator) else $error("reverse without battery");
  AST_TARGET_MAX: assert property (($stable(ireg) && $stable(preg))[*3]
    |-> regulation_target == ((ireg > preg) ? ireg : preg))
    else $error("regulation target not the maximum");
  AST_OV_HOLD: assert property (
    $rose(sense_pins.input_overvolt_sense) && !power_good_n
    |-> (!power_good_n)[*8]) else $error("overvolt acted on unfiltered");
  AST_CAL_ON: assert property (calibrating |-> converter_on)
    else $error("calibrating while off");
  AST_LL_SYNC_CLEAR: assert property ($rose(converter_on) && sync_locked
    |-> ##[0:1] !light_load_enable_bit) else $error("light load kept");
  AST_PFM_OFF: assert property ((!light_load_enable_bit)[*2]
    |-> !pulse_frequency_mode) else $error("pulse skipping while disabled");
  AST_LL_WRITE: assert property (light_load_wr && converter_on
    |=> light_load_enable_bit == $past(light_load_wdata))
    else $error("light load write lost");
endmodule : chg_ctrl_props

bind chg_ctrl chg_ctrl_props chg_ctrl_props_inst (.core_clk, .arst_n,
  .sense_pins, .reverse_enable_bit, .light_load_wr, .light_load_wdata,
  .input_regulation_register, .pin_regulation_level, .power_good_n,
  .gate_drive_regulator, .converter_on, .regulation_target,
  .light_load_enable_bit, .pulse_frequency_mode, .calibrating, .sync_locked);
`default_nettype wire

/* File: tb/chg_ctrl_tb.sv */
// Self-checking testbench for the charger control block
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl_tb import chg_ctrl_pkg::*;;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic core_clk = 1'h0, arst_n = 1'h0, sync_on = 1'h0, light_load = 1'h0;
  logic charge_enable = 1'h0, reverse_enable_bit = 1'h0;
  logic light_load_wr = 1'h0, light_load_wdata = 1'h0;
  logic [PER_W-1:0] period_cycles = 8'h64, duty_cycles = 8'h1e;
  conv_mode_type    mode_sel = MODE_BUCK;
  logic [REG_W-1:0] input_regulation_register = 16'h0000;
  logic [REG_W-1:0] pin_regulation_level = 16'h0000, regulation_target;
  sense_type want = 6'h1e, sense_pins;
  logic freq_set_sync_pin, power_good_n, gate_drive_regulator, calibrating;
  logic host_port_ready, converter_on, input_regulation, sync_locked;
  logic light_load_enable_bit, pulse_frequency_mode;
  gate_type gates;
  int n_errors = 0, total_checks = 0;
  chg_ctrl_partner chg_ctrl_partner_inst (.sync_on, .want, .sense_pins,
    .freq_set_sync_pin);
  chg_ctrl chg_ctrl_inst (.core_clk, .arst_n, .sense_pins, .freq_set_sync_pin,
    .period_cycles, .duty_cycles, .mode_sel, .light_load, .charge_enable,
    .reverse_enable_bit, .light_load_wr, .light_load_wdata,
    .input_regulation_register, .pin_regulation_level, .power_good_n,
    .gate_drive_regulator, .host_port_ready, .converter_on, .input_regulation,
    .regulation_target, .light_load_enable_bit, .pulse_frequency_mode,
    .calibrating, .sync_locked, .gates);
  always #20 core_clk = ~core_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : step
  task check(input logic [REG_W-1:0] seen, exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task wr_ll(input logic v);
    light_load_wr = 1'h1;
    light_load_wdata = v;
    step(1);
    light_load_wr = 1'h0;
    step(1);
  endtask : wr_ll
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task t_battery;
    step(6);
    check(power_good_n, 1'h1, "power good idle");
    check(light_load_enable_bit, LIGHT_LOAD_RESET, "light load reset");
    check(host_port_ready, 1'h1, "host port");
    check(gate_drive_regulator, 1'h0, "regulator battery only");
    reverse_enable_bit = 1'h1;
    step(6);
    check(gate_drive_regulator, 1'h1, "regulator reverse");
    want.battery_ok = 1'h0;
    step(6);
    check(gate_drive_regulator, 1'h0, "reverse low battery");
    reverse_enable_bit = 1'h0;
  endtask : t_battery
  task t_por;
    wr_ll(1'h1);
    check(light_load_enable_bit, 1'h1, "light load write");
    want.input_ok = 1'h1;
    step(6);
    check(light_load_enable_bit, 1'h0, "power-on clear");
    check(power_good_n, 1'h0, "power good low");
    check(converter_on, 1'h0, "no start uncharged");
    want.battery_ok = 1'h1;
  endtask : t_por
  task t_start;
    int n_out;
    int n_in;
    n_out = 0;
    n_in = 0;
    sync_on = 1'h1;
    light_load = 1'h1;
    step(600);
    check(sync_locked, 1'h1, "sync lock");
    wr_ll(1'h1);
    charge_enable = 1'h1;
    step(6);
    check(converter_on, 1'h1, "converter start");
    check(gate_drive_regulator, 1'h1, "regulator forward");
    check(calibrating, 1'h1, "calibration");
    check(light_load_enable_bit, 1'h0, "sync start clear");
    wr_ll(1'h1);
    check(light_load_enable_bit, 1'h1, "write back");
    repeat (300) begin
      step(1);
      n_out += gates.boost_ls;
      n_in += gates.buck_ls;
    end
    check(n_out == 0, 1'h1, "light load skips pulses");
    light_load = 1'h0;
    n_out = 0;
    repeat (300) begin
      step(1);
      n_out += gates.boost_ls;
      n_in += gates.buck_ls;
    end
    check(n_out != 0, 1'h1, "output node toggles");
    check(n_in == 0, 1'h1, "input node quiet");
    wr_ll(1'h0);
    step(3);
    check(pulse_frequency_mode, 1'h0, "fixed frequency");
    sync_on = 1'h0;
  endtask : t_start
  task t_regulation;
    logic [REG_W-1:0] a[3] = '{16'h0000, 16'h2000, 16'h0100};
    logic [REG_W-1:0] b[3] = '{16'h1234, 16'h1234, 16'h0200};
    want.input_undervolt_dpm = 1'h0;
    step(6);
    check(input_regulation, 1'h1, "input regulation");
    want.input_undervolt_dpm = 1'h1;
    for (int i = 0; i < 3; i++) begin
      input_regulation_register = a[i];
      pin_regulation_level = b[i];
      step(4);
      check(regulation_target, (a[i] > b[i]) ? a[i] : b[i], "target");
    end
    check(input_regulation, 1'h0, "regulation released");
  endtask : t_regulation
  task t_faults;
    want.input_undervolt_sense = 1'h0;
    step(6);
    check(power_good_n, 1'h1, "undervolt release");
    check(converter_on, 1'h0, "undervolt stop");
    want.input_undervolt_sense = 1'h1;
    step(6);
    check(power_good_n, 1'h0, "window again");
    want.input_overvolt_sense = 1'h1;
    step(2400);
    check(power_good_n, 1'h0, "overvolt filtered");
    step(200);
    check(power_good_n, 1'h1, "overvolt release");
    check(converter_on, 1'h0, "overvolt stop");
  endtask : t_faults

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    #2 arst_n = 1'h1;
    t_battery;
    t_por;
    t_start;
    t_regulation;
    t_faults;
    give_verdict;
  end
  initial begin
    #4000000;
    n_errors++;
    give_verdict;
  end
endmodule : chg_ctrl_tb
`default_nettype wire
